// file: scw_pkg.sv
// Package: layout, encodings and register map of the status and control word block
package scw_pkg;

  // Bit positions in the status and control word
  localparam int unsigned POS_CF = 0;
  localparam int unsigned POS_R1 = 1;
  localparam int unsigned POS_PF = 2;
  localparam int unsigned POS_AF = 4;
  localparam int unsigned POS_ZF = 6;
  localparam int unsigned POS_SF = 7;
  localparam int unsigned POS_TF = 8;
  localparam int unsigned POS_IF = 9;
  localparam int unsigned POS_DF = 10;
  localparam int unsigned POS_OF = 11;
  localparam int unsigned POS_IO_PRIV_LEVEL_LO = 12;
  localparam int unsigned POS_IO_PRIV_LEVEL_HI = 13;
  localparam int unsigned POS_NT = 14;
  localparam int unsigned POS_RF = 16;
  localparam int unsigned POS_VM = 17;
  localparam int unsigned POS_AC = 18;
  localparam int unsigned POS_AM = 18;

  // Writable bits and fixed reads of reserved bits (bit 1 reads one)
  localparam logic [31:0] WORD_WMASK = 32'h0007_7fd5;
  localparam logic [31:0] WORD_FIXED = 32'h0000_0002;
  localparam logic [31:0] WORD_RESET = 32'h0000_0002;
  localparam logic [31:0] LEGACY_MASK = 32'h0000_ffff;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFS_WORD = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_EN = 8'h0c;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h10;
  localparam logic [7:0] OFS_LEGACY = 8'h14;

  // Interrupt status bit positions
  localparam int unsigned EV_STEP = 0;
  localparam int unsigned EV_ALIGN = 1;
  localparam int unsigned EV_IOFAULT = 2;
  localparam int unsigned EV_PRIVOP = 3;
  localparam int unsigned EV_NUM = 4;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Operation class of a result update from the execution unit
  typedef enum logic [2:0] {
    SCW_OP_NONE,
    SCW_OP_ADD,
    SCW_OP_SUB,
    SCW_OP_LOGIC,
    SCW_OP_POP,
    SCW_OP_INTERRUPT_RETURN_INSTR,
    SCW_OP_TASK
  } scw_op_e;

  // Result update from the execution unit
  typedef struct packed {
    scw_op_e op;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] res;
    logic [31:0] word;
  } scw_exec_s;

  // Instruction-boundary events and privilege context
  typedef struct packed {
    logic retire;
    logic [1:0] current_priv_level;
    logic prot_mode;
    logic io_instr;
    logic priv_instr;
    logic misaligned;
    logic debug_hit;
  } scw_ctx_s;

  // Decisions returned to exception and interrupt logic
  typedef struct packed {
    logic step_trap;
    logic irq_accept;
    logic index_dec;
    logic io_fault;
    logic io_bitmap;
    logic priv_fault;
    logic align_fault;
    logic debug_fault;
    logic legacy_seg;
    logic nested_task;
  } scw_dec_s;

endpackage

// file: scw_arith_flags.sv
// Condition flag computation from an arithmetic or logic result
`timescale 1ns/1ps
module scw_arith_flags (
  input wire scw_pkg::scw_op_e op_i,
  input wire logic [31:0] a_i,
  input wire logic [31:0] b_i,
  input wire logic [31:0] res_i,
  output logic cf_o,
  output logic pf_o,
  output logic af_o,
  output logic zf_o,
  output logic sf_o,
  output logic of_o
);
  // Carry vector into each bit: a ^ b ^ res (b inverted for subtract)
  logic [31:0] bx;
  logic [32:0] full;
  logic [31:0] cin;
  logic arith;
  logic is_sub;

  assign is_sub = (op_i == scw_pkg::SCW_OP_SUB);
  assign arith = (op_i == scw_pkg::SCW_OP_ADD) || is_sub;
  assign bx = is_sub ? ~b_i : b_i;
  // Full sum gives the true carry out of the top bit
  assign full = {1'b0, a_i} + {1'b0, bx} + {32'h0000_0000, is_sub};
  assign cin = a_i ^ bx ^ res_i;

  // Carry out of / borrow out of the top bit
  assign cf_o = arith & (full[32] ^ is_sub);
  // Even count of ones in the low byte
  assign pf_o = ~(^res_i[7:0]);
  // Carry, or borrow for a subtract, across bit 3 into bit 4
  assign af_o = arith & (cin[4] ^ is_sub);
  assign zf_o = (res_i == 32'h0000_0000);
  assign sf_o = res_i[31];
  // Carry into sign bit xor carry out of top bit
  assign of_o = arith & (cin[31] ^ full[32]);
endmodule

// file: scw_flags_reg.sv
// Status and control word register with AXI4-Lite access and event interrupt
`timescale 1ns/1ps
module scw_flags_reg (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // AXI4-Lite slave
  input wire logic [7:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  input wire logic [7:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i,
  // Execution unit and instruction context
  input wire scw_pkg::scw_exec_s exec_i,
  input wire scw_pkg::scw_ctx_s ctx_i,
  input wire logic maskable_irq_pin_i,
  // Decisions and views
  output scw_pkg::scw_dec_s dec_o,
  output logic [31:0] status_control_word_o,
  output logic [15:0] legacy_flags_o,
  output logic irq_o
);
  default clocking cb_main @(posedge ref_clk_i); endclocking // Assertions on the core clock
  default disable iff (rst_i);
  // Mask a value against writable bits and force reserved reads
  function automatic logic [31:0] fix_word(input logic [31:0] v);
    fix_word = (v & scw_pkg::WORD_WMASK) | scw_pkg::WORD_FIXED;
  endfunction

  // Byte-lane merge of a write
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      lane_merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // Architectural state
  logic [31:0] word_q, word_d; // Status and control word
  logic [31:0] ctrl_q; // Control image, bit 18 is the alignment mask
  logic [scw_pkg::EV_NUM-1:0] stat_q, irq_en_q; // Sticky events and enable
  logic [scw_pkg::EV_NUM-1:0] ev; // Events this cycle
  logic [scw_pkg::EV_NUM-1:0] clr_bits; // Software clear this cycle

  // Bus handshake state
  logic aw_held_q, w_held_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  // Trap pending: armed instruction has begun
  logic step_armed_q;

  // Flag computation from result
  logic cf, pf, af, zf, sf, of_f;
  scw_arith_flags u_flags (
    .op_i(exec_i.op),
    .a_i(exec_i.a),
    .b_i(exec_i.b),
    .res_i(exec_i.res),
    .cf_o(cf),
    .pf_o(pf),
    .af_o(af),
    .zf_o(zf),
    .sf_o(sf),
    .of_o(of_f)
  );

  // Bus write decode
  wire aw_ok = aw_held_q || s_awvalid_i;
  wire w_ok = w_held_q || s_wvalid_i;
  wire [7:0] wr_addr = aw_held_q ? aw_addr_q : s_awaddr_i;
  wire [31:0] wr_data = w_held_q ? w_data_q : s_wdata_i;
  wire [3:0] wr_strb = w_held_q ? w_strb_q : s_wstrb_i;
  wire wr_fire = aw_ok && w_ok && !bvalid_q;
  wire wr_word = wr_fire && (wr_addr == scw_pkg::OFS_WORD);
  wire wr_ctrl = wr_fire && (wr_addr == scw_pkg::OFS_CTRL);
  wire wr_en = wr_fire && (wr_addr == scw_pkg::OFS_IRQ_EN);
  wire wr_clr = wr_fire && (wr_addr == scw_pkg::OFS_IRQ_CLR);
  wire wr_hit = wr_word || wr_ctrl || wr_en || wr_clr;

  assign s_awready_o = !aw_held_q && !bvalid_q;
  assign s_wready_o = !w_held_q && !bvalid_q;
  assign s_bvalid_o = bvalid_q;
  assign s_bresp_o = bresp_q;

  // Bus read decode
  wire rd_fire = s_arvalid_i && !rvalid_q;
  wire rd_hit = (s_araddr_i == scw_pkg::OFS_WORD) || (s_araddr_i == scw_pkg::OFS_CTRL) ||
                (s_araddr_i == scw_pkg::OFS_IRQ_STAT) || (s_araddr_i == scw_pkg::OFS_IRQ_EN) ||
                (s_araddr_i == scw_pkg::OFS_IRQ_CLR) || (s_araddr_i == scw_pkg::OFS_LEGACY);
  logic [31:0] rd_val;
  always_comb begin
    // Read mux; clear register reads zero
    case (s_araddr_i)
      scw_pkg::OFS_WORD: rd_val = word_q;
      scw_pkg::OFS_CTRL: rd_val = ctrl_q;
      scw_pkg::OFS_IRQ_STAT: rd_val = {28'h000_0000, stat_q};
      scw_pkg::OFS_IRQ_EN: rd_val = {28'h000_0000, irq_en_q};
      scw_pkg::OFS_LEGACY: rd_val = word_q & scw_pkg::LEGACY_MASK;
      default: rd_val = 32'h0000_0000;
    endcase
  end
  assign s_arready_o = !rvalid_q;
  assign s_rvalid_o = rvalid_q;
  assign s_rdata_o = rdata_q;
  assign s_rresp_o = rresp_q;

  // Current control bits
  wire tf = word_q[scw_pkg::POS_TF];
  wire ief = word_q[scw_pkg::POS_IF];
  wire vm = word_q[scw_pkg::POS_VM];
  wire [1:0] io_priv_level = word_q[scw_pkg::POS_IO_PRIV_LEVEL_HI:scw_pkg::POS_IO_PRIV_LEVEL_LO];
  wire prot = ctx_i.prot_mode;
  wire io_ok = !prot || (ctx_i.current_priv_level <= io_priv_level);
  wire step_fire = step_armed_q && ctx_i.retire;

  // Decisions
  assign dec_o.step_trap = step_fire;
  assign dec_o.irq_accept = maskable_irq_pin_i && ief;
  assign dec_o.index_dec = word_q[scw_pkg::POS_DF];
  assign dec_o.io_fault = ctx_i.io_instr && !io_ok;
  assign dec_o.io_bitmap = dec_o.io_fault;
  assign dec_o.priv_fault = prot && vm && ctx_i.priv_instr;
  assign dec_o.legacy_seg = prot && vm;
  assign dec_o.align_fault = ctx_i.misaligned && word_q[scw_pkg::POS_AC] &&
                             ctrl_q[scw_pkg::POS_AM];
  assign dec_o.debug_fault = ctx_i.retire && ctx_i.debug_hit &&
                             !word_q[scw_pkg::POS_RF];
  assign dec_o.nested_task = prot && word_q[scw_pkg::POS_NT];

  assign status_control_word_o = word_q;
  assign legacy_flags_o = word_q[15:0];

  // Events feeding the interrupt status
  assign ev[scw_pkg::EV_STEP] = step_fire;
  assign ev[scw_pkg::EV_ALIGN] = dec_o.align_fault;
  assign ev[scw_pkg::EV_IOFAULT] = dec_o.io_fault;
  assign ev[scw_pkg::EV_PRIVOP] = dec_o.priv_fault;
  assign clr_bits = wr_clr ? wr_data[scw_pkg::EV_NUM-1:0] : '0;
  assign irq_o = |(stat_q & irq_en_q);

  // Next value of the word
  logic [31:0] popped;
  always_comb begin
    word_d = word_q;
    popped = fix_word(exec_i.word);
    case (exec_i.op)
      scw_pkg::SCW_OP_ADD, scw_pkg::SCW_OP_SUB, scw_pkg::SCW_OP_LOGIC: begin
        word_d[scw_pkg::POS_CF] = cf;
        word_d[scw_pkg::POS_PF] = pf;
        word_d[scw_pkg::POS_AF] = af;
        word_d[scw_pkg::POS_ZF] = zf;
        word_d[scw_pkg::POS_SF] = sf;
        word_d[scw_pkg::POS_OF] = of_f;
      end
      scw_pkg::SCW_OP_POP: begin
        word_d = popped;
        // Enable bit held unless privileged enough
        if (prot && (ctx_i.current_priv_level > io_priv_level)) begin
          word_d[scw_pkg::POS_IF] = ief;
        end
        word_d[scw_pkg::POS_VM] = vm;
      end
      scw_pkg::SCW_OP_INTERRUPT_RETURN_INSTR: begin
        word_d = popped;
        if (prot && (ctx_i.current_priv_level > io_priv_level)) begin
          word_d[scw_pkg::POS_IF] = ief;
        end
        if (ctx_i.current_priv_level != 2'h0) begin
          word_d[scw_pkg::POS_VM] = vm;
        end
      end
      scw_pkg::SCW_OP_TASK: begin
        word_d = popped;
      end
      default: begin
      end
    endcase
    // Software write over the bus, reserved bits fixed
    if (wr_word) begin
      word_d = fix_word(lane_merge(word_q, wr_data, wr_strb));
      word_d[scw_pkg::POS_VM] = vm;
    end
    // Resume bit consumed at the boundary
    if (ctx_i.retire) begin
      word_d[scw_pkg::POS_RF] = 1'b0;
    end
    // Step interrupt clears the trap bit
    if (step_fire) begin
      word_d[scw_pkg::POS_TF] = 1'b0;
    end
  end

  // Word and control registers
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      word_q <= scw_pkg::WORD_RESET;
      ctrl_q <= 32'h0000_0000;
    end else begin
      word_q <= word_d;
      if (wr_ctrl) begin
        ctrl_q <= lane_merge(ctrl_q, wr_data, wr_strb);
      end
    end
  end

  // Trap arms after the instruction that saw it set
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      step_armed_q <= 1'b0;
    end else if (step_fire) begin
      step_armed_q <= 1'b0;
    end else if (ctx_i.retire) begin
      step_armed_q <= tf;
    end
  end

  // Sticky event status: set wins over clear
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stat_q <= '0;
      irq_en_q <= '0;
    end else begin
      stat_q <= (stat_q & ~clr_bits) | ev;
      if (wr_en) begin
        irq_en_q <= wr_data[scw_pkg::EV_NUM-1:0];
      end
    end
  end

  // Write channel capture
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
    end else begin
      if (s_awvalid_i && s_awready_o) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_awaddr_i;
      end
      if (s_wvalid_i && s_wready_o) begin
        w_held_q <= 1'b1;
        w_data_q <= s_wdata_i;
        w_strb_q <= s_wstrb_i;
      end
    end
  end

  // Write response
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bvalid_q <= 1'b0;
      bresp_q <= scw_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? scw_pkg::RESP_OKAY : scw_pkg::RESP_SLVERR;
    end else if (s_bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read response
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= scw_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_hit ? scw_pkg::RESP_OKAY : scw_pkg::RESP_SLVERR;
    end else if (s_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  // Assertions
  sequence s_trap_retire;
    tf && ctx_i.retire && !step_armed_q;
  endsequence
  wire full_carry_add = ({1'b0, exec_i.a} + {1'b0, exec_i.b}) > 33'h0_ffff_ffff;
  property p_carry;
    (exec_i.op == scw_pkg::SCW_OP_ADD && !wr_word) |=>
      word_q[scw_pkg::POS_CF] == $past(full_carry_add);
  endproperty
  a_carry: assert property (p_carry) else $error("carry flag wrong");
  property p_parity;
    (exec_i.op == scw_pkg::SCW_OP_LOGIC && !wr_word) |=>
      word_q[scw_pkg::POS_PF] == !$past(^exec_i.res[7:0]);
  endproperty
  a_parity: assert property (p_parity) else $error("parity flag wrong");
  property p_zero_sign;
    (exec_i.op == scw_pkg::SCW_OP_LOGIC && !wr_word) |=>
      word_q[scw_pkg::POS_ZF] == ($past(exec_i.res) == 32'h0000_0000) &&
      word_q[scw_pkg::POS_SF] == $past(exec_i.res[31]);
  endproperty
  a_zero_sign: assert property (p_zero_sign) else $error("zero or sign flag wrong");
  property p_step;
    step_fire |=> !word_q[scw_pkg::POS_TF];
  endproperty
  a_step: assert property (p_step) else $error("trap bit not cleared");
  property p_irq_mask;
    dec_o.irq_accept |-> word_q[scw_pkg::POS_IF] && maskable_irq_pin_i;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq accepted while masked");
  property p_pop_priv;
    (exec_i.op == scw_pkg::SCW_OP_POP && prot && ctx_i.current_priv_level > io_priv_level && !wr_word) |=>
      $stable(word_q[scw_pkg::POS_IF]);
  endproperty
  a_pop_priv: assert property (p_pop_priv) else $error("enable changed without privilege");
  property p_vm_set;
    $rose(word_q[scw_pkg::POS_VM]) |->
      ($past(exec_i.op) == scw_pkg::SCW_OP_TASK) ||
      ($past(exec_i.op) == scw_pkg::SCW_OP_INTERRUPT_RETURN_INSTR && $past(ctx_i.current_priv_level) == 2'h0);
  endproperty
  a_vm_set: assert property (p_vm_set) else $error("legacy mode set illegally");
  property p_align;
    !ctrl_q[scw_pkg::POS_AM] |-> !dec_o.align_fault;
  endproperty
  a_align: assert property (p_align) else $error("alignment fault while masked");
  property p_reserved;
    ##1 ((word_q & ~scw_pkg::WORD_WMASK) == scw_pkg::WORD_FIXED);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits changed");
  property p_trap_sequence;
    s_trap_retire |=> step_armed_q;
  endproperty
  a_trap_sequence: assert property (p_trap_sequence) else $error("trap not armed");
endmodule

// file: scw_exec_model.sv
// Behavioural execution unit and exception context facing the flags block
`timescale 1ns/1ps
module scw_exec_model (
  input wire logic ref_clk_i,
  output scw_pkg::scw_exec_s exec_o,
  output scw_pkg::scw_ctx_s ctx_o,
  output logic irq_pin_o
);
  // Idle from time zero: no update, no boundary, no request
  initial begin
    exec_o = '0;
    ctx_o = '0;
    irq_pin_o = 1'h0;
  end

  // Present a context for this cycle and let the decisions settle
  task automatic put_ctx(input scw_pkg::scw_ctx_s c);
    ctx_o <= c;
    #1;
  endtask

  // One result update, driven at an edge and taken at the following one
  task automatic run(input scw_pkg::scw_op_e o, input logic [31:0] a, input logic [31:0] b,
                     input logic [31:0] r, input logic [31:0] w);
    @(posedge ref_clk_i);
    exec_o <= '{o, a, b, r, w};
    @(posedge ref_clk_i);
    exec_o.op <= scw_pkg::SCW_OP_NONE;
    #1;
  endtask

  // Maskable request level
  task automatic set_irq(input logic v);
    @(posedge ref_clk_i);
    irq_pin_o <= v;
    #1;
  endtask
endmodule

// file: scw_flags_reg_tb.sv
// Self-checking bench for the status and control word block
`timescale 1ns/1ps
module scw_flags_reg_tb;
  // Clock, reset and bus master drive
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  // Block outputs
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, word, rd;
  logic [15:0] legacy;
  scw_pkg::scw_exec_s exec;
  scw_pkg::scw_ctx_s ctx;
  scw_pkg::scw_dec_s dec;
  logic irq_pin;
  // Score keeping
  int failures = 0;
  int comparisons = 0;

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  scw_exec_model pm_u (.ref_clk_i(ref_clk), .exec_o(exec), .ctx_o(ctx), .irq_pin_o(irq_pin));

  scw_flags_reg dut_u (
    .ref_clk_i(ref_clk), .rst_i(rst),
    .s_awaddr_i(awaddr), .s_awvalid_i(awvalid), .s_awready_o(awready),
    .s_wdata_i(wdata), .s_wstrb_i(wstrb), .s_wvalid_i(wvalid), .s_wready_o(wready),
    .s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready),
    .s_araddr_i(araddr), .s_arvalid_i(arvalid), .s_arready_o(arready),
    .s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvalid), .s_rready_i(rready),
    .exec_i(exec), .ctx_i(ctx), .maskable_irq_pin_i(irq_pin),
    .dec_o(dec), .status_control_word_o(word), .legacy_flags_o(legacy), .irq_o(irq)
  );

  // Compare and report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bus write: address and data offered together, each released when taken
  task automatic bus_wr(input logic [7:0] ad, input logic [31:0] d);
    logic aw_open, w_open;
    aw_open = 1'h1;
    w_open = 1'h1;
    @(posedge ref_clk);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (aw_open || w_open) begin
      @(posedge ref_clk);
      if (aw_open && awready) begin
        aw_open = 1'h0;
        awvalid <= 1'h0;
      end
      if (w_open && wready) begin
        w_open = 1'h0;
        wvalid <= 1'h0;
      end
    end
    do @(posedge ref_clk); while (!bvalid);
    resp = bresp;
    bready <= 1'h0;
    #1;
  endtask

  // Bus read: address held until taken, data taken with the answer
  task automatic bus_rd(input logic [7:0] ad);
    @(posedge ref_clk);
    araddr <= ad;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge ref_clk); while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 1'h0;
    #1;
  endtask

  // Read one register and compare it
  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp);
    bus_rd(ad);
    chk(rd, exp);
  endtask

  // Context word from its fields
  function automatic scw_pkg::scw_ctx_s cx(input int rt, input int current_priv_level, input int pm,
      input int io, input int pv, input int mis, input int dbg);
    cx = {rt[0], current_priv_level[1:0], pm[0], io[0], pv[0], mis[0], dbg[0]};
  endfunction

  // Present a context from the next edge on; it holds until the next one is presented
  task automatic at(input scw_pkg::scw_ctx_s c);
    @(posedge ref_clk);
    pm_u.put_ctx(c);
  endtask

  // Expected condition flags of an add or subtract
  function automatic logic [31:0] arith(input logic sb, input logic [31:0] a,
      input logic [31:0] b);
    logic [32:0] s;
    s = sb ? {1'h0, a} - {1'h0, b} : {1'h0, a} + {1'h0, b};
    arith = 32'h0;
    arith[0] = s[32];
    arith[2] = ~^s[7:0];
    arith[4] = a[4] ^ b[4] ^ s[4];
    arith[6] = (s[31:0] == 32'h0);
    arith[7] = s[31];
    arith[11] = (sb ? a[31] != b[31] : a[31] == b[31]) && (s[31] != a[31]);
  endfunction

  // Reset value, reserved bits, legacy view, direction and request gating, unmapped place
  task automatic t_regs();
    rd_chk(scw_pkg::OFS_WORD, scw_pkg::WORD_RESET);
    bus_wr(scw_pkg::OFS_WORD, 32'hffff_ffff);
    rd_chk(scw_pkg::OFS_WORD, 32'h0005_7fd7);
    rd_chk(scw_pkg::OFS_LEGACY, 32'h0000_7fd7);
    chk(legacy, 32'h7fd7);
    chk(dec.index_dec, 32'h1);
    chk(dec.nested_task, 32'h0);
    pm_u.set_irq(1'h1);
    chk(dec.irq_accept, 32'h1);
    bus_wr(scw_pkg::OFS_WORD, 32'h0);
    chk(dec.index_dec, 32'h0);
    chk(dec.irq_accept, 32'h0);
    @(posedge ref_clk);
    wstrb <= 4'h1;
    bus_wr(scw_pkg::OFS_WORD, 32'hffff_ffff);
    @(posedge ref_clk);
    wstrb <= 4'hf;
    rd_chk(scw_pkg::OFS_WORD, 32'h0000_00d7);
    pm_u.set_irq(1'h0);
    bus_wr(8'h40, 32'h1234_5678);
    chk(resp, scw_pkg::RESP_SLVERR);
    rd_chk(8'h40, 32'h0);
    chk(resp, scw_pkg::RESP_SLVERR);
  endtask

  // Condition flags over carry, overflow, borrow and zero boundaries
  task automatic t_arith();
    logic [31:0] av [5] = '{32'hffff_ffff, 32'h7fff_ffff, 32'h0, 32'h8000_0000, 32'h3};
    logic [31:0] bv [5] = '{32'h1, 32'h1, 32'h1, 32'h1, 32'h4};
    logic sb [5] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0};
    logic [31:0] r;
    for (int i = 0; i < 5; i++) begin
      r = sb[i] ? av[i] - bv[i] : av[i] + bv[i];
      pm_u.run(sb[i] ? scw_pkg::SCW_OP_SUB : scw_pkg::SCW_OP_ADD, av[i], bv[i], r, 32'h0);
      chk(word & 32'h0000_08d5, arith(sb[i], av[i], bv[i]));
    end
  endtask

  // Single step: arm, trap, self-clear, then masked, enabled and cleared interrupt
  task automatic t_trap();
    bus_wr(scw_pkg::OFS_WORD, 32'h0000_0100);
    at(cx(1, 0, 0, 0, 0, 0, 0));
    chk(dec.step_trap, 32'h0);
    at(cx(1, 0, 0, 0, 0, 0, 0));
    chk(dec.step_trap, 32'h1);
    at(cx(0, 0, 0, 0, 0, 0, 0));
    chk(word[8], 32'h0);
    chk(irq, 32'h0);
    rd_chk(scw_pkg::OFS_IRQ_STAT, 32'h1);
    bus_wr(scw_pkg::OFS_IRQ_EN, 32'h1);
    chk(irq, 32'h1);
    bus_wr(scw_pkg::OFS_IRQ_CLR, 32'h1);
    chk(irq, 32'h0);
    rd_chk(scw_pkg::OFS_IRQ_STAT, 32'h0);
  endtask

  // Alignment fault needs both the check bit and the mask
  task automatic t_align();
    bus_wr(scw_pkg::OFS_WORD, 32'h0004_0000);
    at(cx(1, 0, 0, 0, 0, 1, 0));
    chk(dec.align_fault, 32'h0);
    bus_wr(scw_pkg::OFS_CTRL, 32'h0004_0000);
    at(cx(1, 0, 0, 0, 0, 1, 0));
    chk(dec.align_fault, 32'h1);
    bus_wr(scw_pkg::OFS_WORD, 32'h0);
    at(cx(1, 0, 0, 0, 0, 1, 0));
    chk(dec.align_fault, 32'h0);
    rd_chk(scw_pkg::OFS_IRQ_STAT, 32'h2);
  endtask

  // Privilege field, guarded pop, legacy mode entry and resume bit
  task automatic t_priv();
    scw_pkg::scw_op_e ops [4] = '{scw_pkg::SCW_OP_INTERRUPT_RETURN_INSTR, scw_pkg::SCW_OP_INTERRUPT_RETURN_INSTR,
                                  scw_pkg::SCW_OP_TASK, scw_pkg::SCW_OP_TASK};
    int cl [4] = '{3, 0, 3, 3};
    logic [31:0] vw [4] = '{32'h0002_0000, 32'h0002_0000, 32'h0, 32'h0002_0000};
    logic ve [4] = '{1'h0, 1'h1, 1'h0, 1'h1};
    bus_wr(scw_pkg::OFS_WORD, 32'h0000_5200);
    at(cx(1, 2, 1, 1, 0, 0, 0));
    chk(dec.io_fault, 32'h1);
    chk(dec.io_bitmap, 32'h1);
    chk(dec.nested_task, 32'h1);
    at(cx(1, 1, 1, 1, 0, 0, 0));
    chk(dec.io_fault, 32'h0);
    chk(dec.io_bitmap, 32'h0);
    at(cx(0, 2, 1, 0, 0, 0, 0));
    pm_u.run(scw_pkg::SCW_OP_POP, 32'h0, 32'h0, 32'h0, 32'h0);
    chk(word[9], 32'h1);
    at(cx(0, 0, 1, 0, 0, 0, 0));
    pm_u.run(scw_pkg::SCW_OP_POP, 32'h0, 32'h0, 32'h0, 32'h0);
    chk(word[9], 32'h0);
    for (int i = 0; i < 4; i++) begin
      at(cx(0, cl[i], 1, 0, 0, 0, 0));
      pm_u.run(ops[i], 32'h0, 32'h0, 32'h0, vw[i]);
      chk(word[17], ve[i]);
    end
    at(cx(0, 3, 1, 0, 1, 0, 0));
    chk(dec.priv_fault, 32'h1);
    chk(dec.legacy_seg, 32'h1);
    bus_wr(scw_pkg::OFS_WORD, 32'h0001_0000);
    at(cx(1, 0, 0, 0, 0, 0, 1));
    chk(dec.debug_fault, 32'h0);
    at(cx(1, 0, 0, 0, 0, 0, 1));
    chk(dec.debug_fault, 32'h1);
    at(cx(0, 0, 0, 0, 0, 0, 0));
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence after 10 cycles of reset
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'h0;
    t_regs();
    t_arith();
    t_trap();
    t_align();
    t_priv();
    wrap_up();
  end

  // Watchdog against a hung handshake
  initial begin
    #20000;
    failures++;
    wrap_up();
  end
endmodule
